/* verilog/lnk66_pkg.sv */
// shared constants for the 64b/66b transmit link layer
package lnk66_pkg;

	// ----------------------------------------------------------------
	// block and multiblock geometry
	// ----------------------------------------------------------------
	localparam int          PAYLOAD_W   = 64;   // scrambled payload bits per block
	localparam int          BLOCK_W     = 66;   // transmitted block width
	localparam int          OCTETS      = 8;    // octets per block
	localparam int          HDR_W       = 2;    // sync header width
	localparam int          MB_BLOCKS   = 32;   // blocks per multiblock
	localparam logic [4:0]  LAST_BLK    = 5'h1F;
	localparam logic [4:0]  EOEMB_POS   = 5'h16; // bit 22 of stream word
	localparam logic [4:0]  PILOT_POS   = 5'h1B; // first bit of the 00001 pilot
	localparam logic [4:0]  PILOT_PAT   = 5'h01; // oldest bit first in history

	// ----------------------------------------------------------------
	// parity generators
	// ----------------------------------------------------------------
	localparam int          CRC_W       = 12;
	localparam logic [11:0] CRC_TAPS    = 12'h30F;     // x^9+x^8+x^3+x^2+x+1 below x^12
	localparam int          FEC_W       = 26;
	localparam logic [25:0] FEC_TAPS    = 26'h0220211; // x^21+x^17+x^9+x^4+1 below x^26

	// ----------------------------------------------------------------
	// sync header stream layout in CRC-12 mode
	// ----------------------------------------------------------------
	localparam logic [31:0] CRC_ONES    = 32'h80A88888; // bits 3,7,11,15,19,21,23,31
	localparam logic [31:0] CMD_BITS    = 32'h07170000; // bits 16-18,20,24-26

	// ----------------------------------------------------------------
	// sync header mode encodings
	// ----------------------------------------------------------------
	localparam logic [1:0]  MODE_CRC12  = 2'h0;
	localparam logic [1:0]  MODE_FEC    = 2'h2;

	// ----------------------------------------------------------------
	// register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [3:0]  ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_PARITY = 4'h8;
	localparam logic [3:0]  ADDR_STREAM = 4'hC;
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_MODE   = 4;   // two bits
	localparam int          CTRL_EMB    = 8;   // eight bits, E minus one
	localparam logic [7:0]  EMB_RST     = 8'h00;
	localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;

endpackage

/* verilog/lnk66_tx.sv */
// 64b/66b transmit link layer: block build, sync header stream, LEMC, CRC-12/FEC parity
`timescale 1ns/1ns
module lnk66_tx
	import lnk66_pkg::*;
(
	input  wire logic                 hclk,       // line-rate derived clock
	input  wire logic                 hresetn,    // async reset, active low
	input  wire logic                 clk_en,     // freezes all state while low
	input  wire logic                 hsel,       // AHB slave select
	input  wire logic [31:0]          haddr,      // AHB address
	input  wire logic [1:0]           htrans,     // AHB transfer type
	input  wire logic                 hwrite,     // AHB write
	input  wire logic [2:0]           hsize,      // AHB size
	input  wire logic [31:0]          hwdata,     // AHB write data
	input  wire logic                 hready,     // AHB bus ready
	output logic                      hreadyout,  // AHB slave ready
	output logic                      hresp,      // AHB response, always OKAY
	output logic [31:0]               hrdata,     // AHB read data
	input  wire logic                 sysref,     // SYSREF pin, asynchronous
	input  wire logic [PAYLOAD_W-1:0] blk_data,   // scrambled octets, octet n at [8n+7:8n]
	input  wire logic                 blk_valid,  // payload present
	output logic                      blk_ready,  // payload taken this cycle
	output logic [BLOCK_W-1:0]        tx_block,   // 66-bit block, index = bit position
	output logic                      tx_valid,   // block valid
	output logic                      lemc,       // pulse with first block of extended mb
	output logic                      mb_start    // pulse with first block of multiblock
);

	// ----------------------------------------------------------------
	// state declarations
	// ----------------------------------------------------------------
	logic        en_q;                 // link enable
	logic [1:0]  mode_cfg_q;           // programmed sync_header_mode_select
	logic [7:0]  emb_cfg_q;            // programmed E minus one
	logic [1:0]  mode_q;               // mode in force for this multiblock
	logic [7:0]  emb_last_q;           // E minus one in force
	logic        mode_err_q;           // sticky: unsupported mode programmed
	logic [2:0]  sref_q;               // SYSREF synchroniser
	logic        sref_lvl_q;           // filtered SYSREF level
	logic [4:0]  blk_cnt_q;            // block within multiblock
	logic [7:0]  mb_cnt_q;             // multiblock within extended multiblock
	logic [CRC_W-1:0] crc_q;           // running CRC state
	logic [FEC_W-1:0] fec_q;           // running FEC state
	logic [CRC_W-1:0] crc_par_q;       // finished CRC of previous multiblock
	logic [FEC_W-1:0] fec_par_q;       // finished FEC of previous multiblock
	logic [31:0] word_q;               // stream word sent in last complete multiblock
	logic [4:0]  out_blk_q;            // block index of tx_block
	logic [7:0]  out_mb_q;             // multiblock index of tx_block
	logic [1:0]  out_mode_q;           // mode of tx_block
	logic [4:0]  hdr_hist_q;           // last five stream bits sent
	logic        sref_evt;
	logic        mode_bad;
	logic        adv;
	logic        ctrl_wr;
	logic [CRC_W-1:0] crc_d;
	logic [FEC_W-1:0] fec_d;
	logic [31:0] word_d;
	logic        sh_bit;
	logic [PAYLOAD_W-1:0] payload;
	logic        ap_wr_q;
	logic [3:0]  ap_addr_q;

	// ----------------------------------------------------------------
	// parity helpers
	// ----------------------------------------------------------------
	// serial order: octet 0 first, each octet most significant bit first
	function automatic logic ser_bit(input logic [PAYLOAD_W-1:0] d, input int i);
		ser_bit = d[8 * (i / 8) + 7 - (i % 8)];
	endfunction

	function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] s,
	                                              input logic [PAYLOAD_W-1:0] d);
		logic [CRC_W-1:0] r;
		logic             fb;
		r = s;
		for (int i = 0; i < PAYLOAD_W; i++) begin
			fb = ser_bit(d, i) ^ r[CRC_W-1];
			r  = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_TAPS : '0);
		end
		crc_step = r;
	endfunction

	function automatic logic [FEC_W-1:0] fec_step(input logic [FEC_W-1:0] s,
	                                              input logic [PAYLOAD_W-1:0] d);
		logic [FEC_W-1:0] r;
		logic             fb;
		r = s;
		for (int i = 0; i < PAYLOAD_W; i++) begin
			fb = ser_bit(d, i) ^ r[FEC_W-1];
			r  = {r[FEC_W-2:0], 1'b0} ^ (fb ? FEC_TAPS : '0);
		end
		fec_step = r;
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite slave: zero wait states, frozen with the clock enable
	// ----------------------------------------------------------------
	assign hreadyout = clk_en;
	assign hresp     = 1'b0;

	// address phase capture; read data prepared for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= '0;
			hrdata    <= '0;
		end else if (clk_en && hready) begin
			ap_wr_q   <= hsel && htrans == HTRANS_NSEQ && hwrite;
			ap_addr_q <= haddr[3:0];
			if (hsel && htrans == HTRANS_NSEQ && !hwrite) begin
				case (haddr[3:0])
					ADDR_CTRL:   hrdata <= {16'h0000, emb_cfg_q, 2'b00, mode_cfg_q,
					                        3'b000, en_q};
					ADDR_STATUS: hrdata <= {15'h0000, mode_err_q, mb_cnt_q, 3'b000,
					                        blk_cnt_q};
					ADDR_PARITY: hrdata <= {6'h00, (mode_q == MODE_FEC) ? fec_par_q
					                        : {14'h0000, crc_par_q}};
					ADDR_STREAM: hrdata <= word_q;
					default:     hrdata <= '0; // unmapped reads as zero
				endcase
			end
		end
	end

	// a control write lands in the data phase, one edge after its address
	assign ctrl_wr = clk_en && ap_wr_q && ap_addr_q == ADDR_CTRL;

	// control register write; unsupported modes raise a sticky flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q       <= 1'b0;
			mode_cfg_q <= MODE_CRC12;
			emb_cfg_q  <= EMB_RST;
		end else if (ctrl_wr) begin
			en_q       <= hwdata[CTRL_EN];
			mode_cfg_q <= hwdata[CTRL_MODE +: 2];
			emb_cfg_q  <= hwdata[CTRL_EMB +: 8];
		end
	end

	assign mode_bad = mode_cfg_q != MODE_CRC12 && mode_cfg_q != MODE_FEC;

	// sticky error: a new bad mode wins over a status write clearing it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_err_q <= 1'b0;
		end else if (clk_en) begin
			if (mode_bad)
				mode_err_q <= 1'b1;
			else if (ap_wr_q && ap_addr_q == ADDR_STATUS && hwdata[16])
				mode_err_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// SYSREF capture: three flops, edge once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sref_q     <= '0;
			sref_lvl_q <= 1'b0;
		end else if (clk_en) begin
			sref_q <= {sref_q[1:0], sysref};
			if (sref_q[1] == sref_q[2])
				sref_lvl_q <= sref_q[2];
		end
	end

	assign sref_evt = sref_q[1] && sref_q[2] && !sref_lvl_q;

	// ----------------------------------------------------------------
	// block and multiblock counters (the LEMC)
	// ----------------------------------------------------------------
	assign adv       = clk_en && en_q;
	assign blk_ready = adv;                       // taken only while enabled and clocked
	assign payload   = blk_valid ? blk_data : '0; // idle blocks carry zeros

	// period of 32 x E blocks of 66 bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blk_cnt_q <= '0;
			mb_cnt_q  <= '0;
		end else if (sref_evt && clk_en) begin
			blk_cnt_q <= '0;
			mb_cnt_q  <= '0;
		end else if (adv) begin
			blk_cnt_q <= blk_cnt_q + 5'h01;
			if (blk_cnt_q == LAST_BLK)
				mb_cnt_q <= (mb_cnt_q >= emb_last_q) ? 8'h00 : mb_cnt_q + 8'h01;
		end
	end

	// E and the mode change only at a multiblock boundary
	// value 0 selects CRC-12, value 2 selects FEC
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q     <= MODE_CRC12;
			emb_last_q <= EMB_RST;
		end else if (ctrl_wr && !en_q) begin
			// the enabling write itself: block 0 must already use its fields
			mode_q     <= (hwdata[CTRL_MODE +: 2] == MODE_FEC) ? MODE_FEC : MODE_CRC12;
			emb_last_q <= hwdata[CTRL_EMB +: 8];
		end else if (clk_en && (!en_q || blk_cnt_q == LAST_BLK || sref_evt)) begin
			mode_q     <= mode_bad ? MODE_CRC12 : mode_cfg_q;
			emb_last_q <= emb_cfg_q;
		end
	end

	// ----------------------------------------------------------------
	// parity accumulation over the scrambled payload only
	// ----------------------------------------------------------------
	// CRC-12 update; FEC update
	assign crc_d = crc_step(crc_q, payload);
	assign fec_d = fec_step(fec_q, payload);

	// state cleared at every multiblock, result read after block 31
	// parity of this multiblock is held for the next one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crc_q     <= '0;
			fec_q     <= '0;
			crc_par_q <= '0;
			fec_par_q <= '0;
		end else if (sref_evt && clk_en) begin
			crc_q <= '0;
			fec_q <= '0;
		end else if (adv) begin
			if (blk_cnt_q == LAST_BLK) begin
				crc_q     <= '0;
				fec_q     <= '0;
				crc_par_q <= crc_d;
				fec_par_q <= fec_d;
			end else begin
				crc_q <= crc_d;
				fec_q <= fec_d;
			end
		end
	end

	// ----------------------------------------------------------------
	// sync header stream word for the current multiblock
	// ----------------------------------------------------------------
	always_comb begin
		word_d = '0;
		if (mode_q == MODE_FEC) begin
			// FEC word layout
			// parity leaves most significant bit first, so stream order is reversed
			word_d[21:0]  = {<<{fec_par_q[25:4]}};
			word_d[23]    = fec_par_q[3];
			word_d[26:24] = {<<{fec_par_q[2:0]}};
		end else begin
			// CRC-12 layout, fixed ones and parity triplets
			word_d        = CRC_ONES;
			word_d[2:0]   = {<<{crc_par_q[11:9]}};
			word_d[6:4]   = {<<{crc_par_q[8:6]}};
			word_d[10:8]  = {<<{crc_par_q[5:3]}};
			word_d[14:12] = {<<{crc_par_q[2:0]}};
			word_d        = word_d & ~CMD_BITS;
		end
		word_d[31:27] = 5'b10000;
		word_d[EOEMB_POS] = mb_cnt_q >= emb_last_q;
	end

	// stream bit of this block; block n carries bit n
	assign sh_bit = word_d[blk_cnt_q];

	// ----------------------------------------------------------------
	// block output register
	// ----------------------------------------------------------------
	// eight octets packed; octet n at positions 2+8n
	// header prepended to the scrambled payload
	// header is 01 or 10 only; 01 carries a one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_block   <= '0;
			tx_valid   <= 1'b0;
			lemc       <= 1'b0;
			mb_start   <= 1'b0;
			out_blk_q  <= '0;
			out_mb_q   <= '0;
			out_mode_q <= MODE_CRC12;
			hdr_hist_q <= '0;
			word_q     <= '0;
		end else if (clk_en) begin
			tx_valid <= adv && !sref_evt;
			lemc     <= adv && !sref_evt && blk_cnt_q == '0 && mb_cnt_q == '0;
			mb_start <= adv && !sref_evt && blk_cnt_q == '0;
			if (adv && !sref_evt) begin
				tx_block   <= {payload, sh_bit, ~sh_bit};
				out_blk_q  <= blk_cnt_q;
				out_mb_q   <= mb_cnt_q;
				out_mode_q <= mode_q;
				hdr_hist_q <= {hdr_hist_q[3:0], sh_bit};
				if (blk_cnt_q == LAST_BLK)
					word_q <= word_d;
			end
		end
	end

	// a periodic SYSREF at the LEMC rate lands on block 0 again
	// the far end relies on the fixed header transition
	// the far end checks parity carried one multiblock later

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	hdr_compl_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_valid |-> tx_block[0] != tx_block[1])
		else $error("sync header not complementary");

	eomb_pilot_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_valid && out_blk_q == LAST_BLK |-> hdr_hist_q == PILOT_PAT)
		else $error("end-of-multiblock pilot missing");

	eoemb_flag_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_valid && out_blk_q == EOEMB_POS |-> tx_block[1] == (out_mb_q >= emb_last_q))
		else $error("extended multiblock flag wrong");

	cmd_zero_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_valid && out_mode_q == MODE_CRC12 && CMD_BITS[out_blk_q] |-> !tx_block[1])
		else $error("command bit sent as one");

	crc_ones_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_valid && out_mode_q == MODE_CRC12 && CRC_ONES[out_blk_q] |-> tx_block[1])
		else $error("fixed one missing in stream");

	blk_step_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		adv && !sref_evt ##1 clk_en && tx_valid |=>
		tx_valid |-> out_blk_q == $past(out_blk_q) + 5'h01)
		else $error("block index did not advance by one");

	crc_clear_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		adv && !sref_evt && blk_cnt_q == LAST_BLK |=> crc_q == '0 && crc_par_q == $past(crc_d))
		else $error("crc state not cleared at multiblock end");

	sref_phase_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		sref_evt && clk_en |=> blk_cnt_q == '0 && mb_cnt_q == '0)
		else $error("SYSREF did not reset the multiblock phase");

	lemc_phase_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		lemc |-> mb_start && out_blk_q == '0 && out_mb_q == '0)
		else $error("LEMC pulse off its block");

endmodule

/* test/lnk66_rx_model.sv */
// receiving link end model: header, stream word and parity checks
`timescale 1ns/1ns
module lnk66_rx_model
	import lnk66_pkg::*;
(
	input  wire logic               hclk,     // line clock
	input  wire logic               hresetn,  // reset, active low
	input  wire logic [BLOCK_W-1:0] tx_block, // received block
	input  wire logic               tx_valid, // block present
	input  wire logic               mb_start, // first block mark
	input  wire logic [1:0]         mode,     // parity format
	output logic [31:0]             word_q,   // last whole stream word
	output int                      nword_q,  // words seen
	output int                      err_q     // faults seen
);
	logic [11:0] crc, pc, pcrc;
	logic [25:0] fec, pf, pfec;
	logic [31:0] w;
	logic        b, skip;
	int          cnt;

	// ----------------------------------------------------------------
	// block receive
	// ----------------------------------------------------------------
	// blocking updates; the bench samples these off the clock edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{crc, fec, pcrc, pfec, w, word_q, skip} = '0;
			{nword_q, err_q} = '0;
			cnt = 32;
		end else if (tx_valid === 1'b1) begin
			if (mb_start === 1'b1) begin
				skip = skip | (cnt != 32);
				cnt = 0;
				crc = '0;
				fec = '0;
			end else if (cnt == 32) begin
				err_q++;
			end
			if (tx_block[0] === tx_block[1]) err_q++;
			// header bit lands at its index
			w[cnt] = tx_block[1];
			// octet 0 first, msb first, x^12 implied
			for (int i = 0; i < 64; i++) begin
				b = tx_block[2 + (i / 8) * 8 + 7 - i % 8];
				crc = {crc[10:0], 1'b0} ^ ({12{b ^ crc[11]}} & 12'h30F);
				fec = {fec[24:0], 1'b0} ^ ({26{b ^ fec[25]}} & 26'h0220211);
			end
			cnt++;
			if (cnt == 32) begin
				pc = {w[0], w[1], w[2], w[4], w[5], w[6], w[8], w[9], w[10], w[12],
					w[13], w[14]};
				for (int i = 0; i < 22; i++) pf[25 - i] = w[i];
				pf[3:0] = {w[23], w[24], w[25], w[26]};
				if (!skip && (mode == MODE_FEC ? pf !== pfec : pc !== pcrc)) err_q++;
				pcrc = crc;
				pfec = fec;
				skip = 1'b0;
				word_q = w;
				nword_q++;
			end
		end
	end
endmodule

/* test/lnk66_tx_test.sv */
// self-checking bench for the 64b/66b transmit link layer
`timescale 1ns/1ns
module lnk66_tx_test
	import lnk66_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, sysref, blk_valid;
	logic        hreadyout, hresp, blk_ready, tx_valid, lemc, mb_start;
	logic [31:0] haddr, hwdata, hrdata, w, rd;
	logic [1:0]  htrans, mode_v;
	logic [2:0]  hsize;
	logic [63:0] blk_data = 64'h0123456789ABCDEF;
	logic [63:0] d_q;
	logic [65:0] tx_block;
	int          error_cnt, num_checks, nword, nerr;
	int          nlemc = 0;
	int          nmb = 0;

	lnk66_tx DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .sysref(sysref), .blk_data(blk_data), .blk_valid(blk_valid),
		.blk_ready(blk_ready), .tx_block(tx_block), .tx_valid(tx_valid), .lemc(lemc),
		.mb_start(mb_start));

	lnk66_rx_model rx (.hclk(hclk), .hresetn(hresetn), .tx_block(tx_block),
		.tx_valid(tx_valid), .mb_start(mb_start), .mode(mode_v), .word_q(w),
		.nword_q(nword), .err_q(nerr));

	// ----------------------------------------------------------------
	// clock, payload source, observers
	// ----------------------------------------------------------------
	always #5 hclk = ~hclk;

	// changing payload every block so parity faults cannot hide
	always @(posedge hclk) begin
		blk_data <= blk_data * 64'h5851F42D4C957F2D + 64'h14057B7EF767814F;
		d_q <= (blk_valid && blk_ready) ? blk_data : 64'h0;
		if (lemc === 1'b1) nlemc++;
		if (mb_start === 1'b1) nmb++;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one single word transfer; waits on hready in both phases
	task automatic ahb(input logic wr_n, input logic [3:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {28'h0, a};
		htrans <= HTRANS_NSEQ;
		hwrite <= wr_n;
		hsize <= HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic do_reset(input logic [1:0] m);
		@(posedge hclk);
		hresetn <= 1'b0;
		mode_v <= m;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	// waits for the next whole stream word and checks its pilot
	task automatic next_word(input logic eoemb);
		int n;
		n = nword;
		for (int t = 0; t < 100 && nword == n; t++) @(negedge hclk);
		check(nword, n + 1);
		check(w[31:27], 5'h10);
		check(w[22], eoemb);
		if (mode_v == MODE_CRC12) begin
			check(w & 32'h80A88888, 32'h80A88888);
			check(w & 32'h07170000, 32'h0);
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		do_reset(MODE_CRC12);
		ahb(1'b0, ADDR_CTRL, 32'h0);
		check(rd, 32'h0);
		ahb(1'b1, ADDR_PARITY, 32'hFFFFFFFF);
		ahb(1'b0, ADDR_PARITY, 32'h0);
		check(rd, 32'h0);
		ahb(1'b1, ADDR_CTRL, 32'h00000010);
		ahb(1'b0, ADDR_STATUS, 32'h0);
		check(rd[16], 1'b1);
		check({hresp, blk_ready}, 2'b00);
		ahb(1'b1, ADDR_CTRL, 32'h0);
		ahb(1'b1, ADDR_STATUS, 32'h00010000);
		ahb(1'b0, ADDR_STATUS, 32'h0);
		check(rd[16], 1'b0);
	endtask

	// two multiblocks per extended multiblock, crc words
	task automatic t_crc();
		int l0, m0;
		do_reset(MODE_CRC12);
		ahb(1'b1, ADDR_CTRL, 32'h00000101);
		l0 = nlemc;
		m0 = nmb;
		for (int i = 0; i < 4; i++) next_word(i[0]);
		check(nmb - m0, 4);
		check(nlemc - l0, 2);
		ahb(1'b0, ADDR_STREAM, 32'h0);
		check(rd, w);
		@(negedge hclk);
		check(tx_block[33:2], d_q[31:0]);
		check(tx_block[65:34], d_q[63:32]);
		check({hresp, blk_ready}, 2'b01);
		@(posedge hclk);
		blk_valid <= 1'b0;
		repeat (2) @(negedge hclk);
		check(tx_block[65:34] | tx_block[33:2], 32'h0);
		@(posedge hclk);
		blk_valid <= 1'b1;
		next_word(1'b0);
		check(nerr, 0);
	endtask

	task automatic t_fec();
		do_reset(MODE_FEC);
		ahb(1'b1, ADDR_CTRL, 32'h00000021);
		for (int i = 0; i < 3; i++) next_word(1'b1);
		check(nerr, 0);
	endtask

	// sysref in mid multiblock restarts the boundaries
	task automatic t_sysref();
		do_reset(MODE_CRC12);
		ahb(1'b1, ADDR_CTRL, 32'h00000001);
		repeat (40) @(posedge hclk);
		// one-shot pulse; a periodic one would have to match the LEMC rate
		sysref <= 1'b1;
		repeat (2) @(posedge hclk);
		sysref <= 1'b0;
		for (int t = 0; t < 12 && mb_start !== 1'b1; t++) @(negedge hclk);
		check(mb_start, 1'b1);
		check(lemc, 1'b1);
		next_word(1'b1);
		next_word(1'b1);
		check(nerr, 0);
	endtask

	initial begin
		{hclk, hsel, hwrite, sysref, htrans, hsize, haddr, hwdata, mode_v} = '0;
		{error_cnt, num_checks} = '0;
		hresetn = 1'b0;
		blk_valid = 1'b1;
		t_regs();
		t_crc();
		t_fec();
		t_sysref();
		results();
	end

	// watchdog: all scenarios need well under a thousand cycles
	initial begin
		#60000;
		error_cnt++;
		results();
	end
endmodule
